// ==== pkg/scp_pkg.sv ====
// shared constants and types of the serial control port
package scp_pkg;

  // ==========================================================================
  // register map
  localparam int unsigned AW             = 13;
  localparam logic [12:0] CONFIG_ADDR    = 13'h0000;
  localparam logic [12:0] READBACK_ADDR  = 13'h0001;
  localparam logic [12:0] UPDATE_ADDR    = 13'h000f;
  localparam logic [12:0] LAST_ADDR      = 13'h1fff;
  localparam logic [7:0]  UPDATE_CMD     = 8'h01;
  localparam int          LSB_FIRST_BIT  = 6;
  localparam int          ASCEND_BIT     = 5;
  localparam int          READ_ACT_BIT   = 5;
  localparam logic [7:0]  CONFIG_RESET   = 8'h00;
  localparam logic [7:0]  READBACK_RESET = 8'h00;

  // ==========================================================================
  // four-wire frame bit counts
  localparam logic [4:0]  INSTR_LAST     = 5'h0f;
  localparam logic [4:0]  DATA_FIRST     = 5'h10;
  localparam logic [4:0]  DATA_MID       = 5'h12;
  localparam logic [4:0]  DATA_LAST      = 5'h17;

  // ==========================================================================
  // two-wire port
  localparam logic [3:0]  BYTE_LAST      = 4'h7;
  localparam logic [3:0]  BYTE_BITS      = 4'h8;
  localparam logic [6:0]  SLAVE_ADDR_DEF = 7'h48;

  typedef enum logic [1:0] {EV_INSTR, EV_MID, EV_END} scp_ev_kind_t;
  typedef enum logic [2:0] {I_IDLE, I_RX, I_RX_ACK, I_TX, I_TX_ACK} scp_i2c_st_t;

endpackage : scp_pkg

// ==== rtl/scp_mem.sv ====
// byte-wide register storage with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
module scp_mem (
  // clock
  input  wire logic        clk_i,
  // write port
  input  wire logic        we_i,
  input  wire logic [12:0] waddr_i,
  input  wire logic [7:0]  wdata_i,
  // read port
  input  wire logic [12:0] raddr_i,
  output logic      [7:0]  rdata_o
);

  logic [7:0] mem [2**scp_pkg::AW];

  // no reset: contents are data, read data settle one edge after the address
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule : scp_mem
`default_nettype wire

// ==== rtl/scp_serial_port.sv ====
// serial register port: four-wire and two-wire access to a buffered byte map
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - frame opens with 16-bit instruction, rw first (last in lsb-first order)
// - upper two address bits ignored as zero
// - config bit 6 selects lsb-first shifting
// - bit order change acts on next operation
// - ascension bit zero decrements the address
// - ascension bit one increments the address
// - streaming never skips any address
// - two-wire slave runs at 100/400 kHz
// - slave never drives the clock line
// - write carries two address bytes, high first
// - answer only to own seven-bit address
// - address byte msb first plus direction
// - data line changes only while clock low
// - detect start and stop while clock high
// - eight-bit bytes msb first plus ack
// - ninth clock low acknowledges, high refuses
// - after own non-acknowledge go idle
// - master non-acknowledge ends the read
// - read returns data from current address
// - no limit on burst length
// - start or stop aborts, partial byte dropped
// - readback from buffered or active copy
// - update command copies buffered to active
module scp_serial_port #(
  parameter logic [6:0] SLAVE_ADDR = scp_pkg::SLAVE_ADDR_DEF
) (
  // system clock and reset
  input  wire logic CLK_I,
  input  wire logic RESET_N_I,
  // four-wire port, clocked by the host
  input  wire logic SCLK_I,
  input  wire logic CS_N_I,
  input  wire logic SDIO_I,
  output logic      SDO_O,
  // two-wire slave port
  input  wire logic SCL_I,
  input  wire logic SDA_I,
  output logic      SDA_O,
  output logic      SDA_OE_N_O,
  // status
  output logic      UPDATE_BUSY_O,
  output logic      LSB_FIRST_O
);

  // ==========================================================================
  // state types
  typedef struct packed {
    logic [4:0]  cnt;
    logic [14:0] sh;
    logic [7:0]  out;
    logic        first;
  } scp_spi_t;
  typedef struct packed {
    logic                 tgl;
    scp_pkg::scp_ev_kind_t kind;
    logic [15:0]          word;
  } scp_evt_t;
  typedef struct packed {
    logic [7:0]           cfg, rbk, rsp, rsp_spi;
    logic [2:0]           ev_s;
    logic [12:0]          ptr, cp_addr, cp_waddr;
    logic [1:0]           scl_s, sda_s, idx;
    logic                 spi_rd, rd_pend, cp_busy, cp_wr, scl_q, sda_q;
    scp_pkg::scp_i2c_st_t ist;
    logic [3:0]           bitc;
    logic [7:0]           sh;
    logic                 rd, ack, phase, oe_n;
  } scp_core_t;

  scp_spi_t    sp, next_sp;
  scp_evt_t    ev, next_ev;
  scp_core_t   c, next_c;
  logic [15:0] bit_word, instr_w;
  logic [12:0] spi_next, wa, ra;
  logic [7:0]  wr_byte, rdata, buf_rdata, act_rdata, rx_byte, wd;
  logic        spi_rst_n, ev_pulse, scl_rise, scl_fall, start, stop, buf_we, rd_req;

  // ==========================================================================
  // host-clocked side: shifts and counts bits, bit order is resolved in the core
  assign spi_rst_n = RESET_N_I & ~CS_N_I;
  assign bit_word  = {sp.sh, SDIO_I};
  always_comb begin
    next_sp    = sp;
    next_ev    = ev;
    next_sp.sh = bit_word[14:0];
    if (sp.cnt < scp_pkg::INSTR_LAST) begin
      next_sp.cnt = sp.cnt + 5'h01;
    end else if (sp.cnt == scp_pkg::INSTR_LAST) begin
      // sixteen bits in: hand the whole instruction over
      next_sp.cnt   = scp_pkg::DATA_FIRST;
      next_sp.first = 1'b1;
      next_ev.tgl   = ~ev.tgl;
      next_ev.kind  = scp_pkg::EV_INSTR;
      next_ev.word  = bit_word;
    end else begin
      next_sp.out   = sp.first ? {c.rsp_spi[6:0], 1'b0} : {sp.out[6:0], 1'b0};
      next_sp.first = 1'b0;
      next_sp.cnt   = (sp.cnt == scp_pkg::DATA_LAST) ? scp_pkg::DATA_FIRST : sp.cnt + 5'h01;
      // mid-byte event gives the core five bit times to prefetch
      if (sp.cnt == scp_pkg::DATA_MID) begin
        next_ev.tgl  = ~ev.tgl;
        next_ev.kind = scp_pkg::EV_MID;
      end
      if (sp.cnt == scp_pkg::DATA_LAST) begin
        next_sp.first = 1'b1;
        next_ev.tgl   = ~ev.tgl;
        next_ev.kind  = scp_pkg::EV_END;
        next_ev.word  = {8'h00, bit_word[7:0]};
      end
    end
  end
  // frame state dies with chip select high
  always_ff @(posedge SCLK_I or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      sp <= '0;
    end else begin
      sp <= next_sp;
    end
  end
  // event toggle must survive frame ends, else the core sees a false event
  always_ff @(posedge SCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ev <= '0;
    end else begin
      ev <= next_ev;
    end
  end
  // first bit of each read byte comes straight from the prefetched word
  assign SDO_O = sp.first ? c.rsp_spi[7] : sp.out[7];

  // ==========================================================================
  // core decode helpers
  assign ev_pulse = c.ev_s[1] ^ c.ev_s[2];
  assign instr_w  = c.cfg[scp_pkg::LSB_FIRST_BIT] ? {<<{ev.word}} : ev.word;
  assign wr_byte  = c.cfg[scp_pkg::LSB_FIRST_BIT] ? {<<{ev.word[7:0]}} : ev.word[7:0];
  assign spi_next = c.cfg[scp_pkg::ASCEND_BIT] ? c.ptr + 13'h0001 : c.ptr - 13'h0001;
  assign rdata    = c.rbk[scp_pkg::READ_ACT_BIT] ? act_rdata : buf_rdata;
  assign scl_rise = c.scl_s[1] & ~c.scl_q;
  assign scl_fall = ~c.scl_s[1] & c.scl_q;
  assign start    = c.scl_s[1] & c.scl_q & c.sda_q & ~c.sda_s[1];
  assign stop     = c.scl_s[1] & c.scl_q & ~c.sda_q & c.sda_s[1];
  assign rx_byte  = {c.sh[6:0], c.sda_s[1]};

  // ==========================================================================
  // core next state
  always_comb begin
    next_c       = c;
    buf_we       = 1'b0;
    wa           = c.ptr;
    wd           = 8'h00;
    rd_req       = 1'b0;
    ra           = c.ptr;
    next_c.ev_s  = {c.ev_s[1:0], ev.tgl};
    next_c.scl_s = {c.scl_s[0], SCL_I}; // both line rates well above 4 clocks a phase
    next_c.sda_s = {c.sda_s[0], SDA_I};
    next_c.scl_q = c.scl_s[1];
    next_c.sda_q = c.sda_s[1];
    next_c.cp_wr = 1'b0;
    // read data return, kept raw for two-wire and in line order for four-wire
    if (c.rd_pend) begin
      next_c.rsp     = rdata;
      next_c.rsp_spi = c.cfg[scp_pkg::LSB_FIRST_BIT] ? {<<{rdata}} : rdata;
    end
    // four-wire events
    if (ev_pulse) begin
      case (ev.kind)
        scp_pkg::EV_INSTR: begin
          next_c.spi_rd = instr_w[15];
          next_c.ptr    = instr_w[12:0]; // addr_bit_fourteen/thirteen dropped
          if (instr_w[15]) begin
            rd_req = 1'b1;
            ra     = instr_w[12:0];
          end
        end
        scp_pkg::EV_MID: begin
          if (c.spi_rd) begin
            next_c.ptr = spi_next;
            rd_req     = 1'b1;
            ra         = spi_next;
          end
        end
        scp_pkg::EV_END: begin
          if (!c.spi_rd) begin
            buf_we     = 1'b1;
            wd         = wr_byte;
            next_c.ptr = spi_next;
          end
        end
        default: ;
      endcase
    end
    // two-wire slave; a start or stop wins over any bit in flight
    if (start) begin
      next_c.ist  = scp_pkg::I_RX;
      next_c.bitc = 4'h0;
      next_c.idx  = 2'd0;
      next_c.oe_n = 1'b1;
    end else if (stop) begin
      next_c.ist  = scp_pkg::I_IDLE;
      next_c.oe_n = 1'b1;
    end else begin
      case (c.ist)
        scp_pkg::I_RX: begin
          if (scl_rise) begin
            next_c.sh   = rx_byte;
            next_c.bitc = c.bitc + 4'h1;
            if (c.bitc == scp_pkg::BYTE_LAST) begin
              next_c.ist   = scp_pkg::I_RX_ACK;
              next_c.phase = 1'b0;
              next_c.ack   = 1'b1;
              next_c.idx   = (c.idx == 2'd3) ? c.idx : c.idx + 2'd1;
              case (c.idx)
                2'd0: begin
                  next_c.ack = (rx_byte[7:1] == SLAVE_ADDR);
                  next_c.rd  = rx_byte[0];
                  if ((rx_byte[7:1] == SLAVE_ADDR) && rx_byte[0]) begin
                    rd_req = 1'b1;
                    ra     = c.ptr;
                  end
                end
                2'd1: next_c.ptr = {rx_byte[4:0], c.ptr[7:0]};
                2'd2: next_c.ptr = {c.ptr[12:8], rx_byte};
                default: begin
                  buf_we     = 1'b1;
                  wd         = rx_byte;
                  next_c.ptr = c.ptr + 13'h0001;
                end
              endcase
            end
          end
        end
        scp_pkg::I_RX_ACK: begin
          if (scl_fall && !c.phase) begin
            next_c.oe_n  = ~c.ack;
            next_c.phase = 1'b1;
          end else if (scl_fall) begin
            next_c.oe_n = 1'b1;
            next_c.bitc = 4'h0;
            if (!c.ack) begin
              next_c.ist = scp_pkg::I_IDLE;
            end else if (c.rd) begin
              next_c.ist  = scp_pkg::I_TX;
              next_c.sh   = c.rsp;
              next_c.oe_n = c.rsp[7];
            end else begin
              next_c.ist = scp_pkg::I_RX;
            end
          end
        end
        scp_pkg::I_TX: begin
          if (scl_rise) begin
            next_c.bitc = c.bitc + 4'h1;
          end else if (scl_fall && (c.bitc == scp_pkg::BYTE_BITS)) begin
            next_c.oe_n  = 1'b1; // let the master drive its acknowledge
            next_c.ist   = scp_pkg::I_TX_ACK;
            next_c.phase = 1'b0;
          end else if (scl_fall) begin
            next_c.sh   = {c.sh[6:0], 1'b0};
            next_c.oe_n = c.sh[6];
          end
        end
        scp_pkg::I_TX_ACK: begin
          if (scl_rise && !c.phase) begin
            if (c.sda_s[1]) begin
              next_c.ist = scp_pkg::I_IDLE;
            end else begin
              next_c.ptr   = c.ptr + 13'h0001;
              rd_req       = 1'b1;
              ra           = c.ptr + 13'h0001;
              next_c.phase = 1'b1;
            end
          end else if (scl_fall && c.phase) begin
            next_c.ist  = scp_pkg::I_TX;
            next_c.bitc = 4'h0;
            next_c.sh   = c.rsp;
            next_c.oe_n = c.rsp[7];
          end
        end
        default: ;
      endcase
    end
    // copy walk yields the buffer read port to serial reads
    if (c.cp_busy && !rd_req) begin
      ra              = c.cp_addr;
      next_c.cp_wr    = 1'b1;
      next_c.cp_waddr = c.cp_addr;
      next_c.cp_addr  = c.cp_addr + 13'h0001;
      if (c.cp_addr == scp_pkg::LAST_ADDR) begin
        next_c.cp_busy = 1'b0;
      end
    end
    // live effects of a register write
    if (buf_we && (wa == scp_pkg::CONFIG_ADDR)) begin
      next_c.cfg = wd;
    end
    if (buf_we && (wa == scp_pkg::READBACK_ADDR)) begin
      next_c.rbk = wd;
    end
    if (buf_we && (wa == scp_pkg::UPDATE_ADDR) && (wd == scp_pkg::UPDATE_CMD)) begin
      next_c.cp_busy = 1'b1;
      next_c.cp_addr = 13'h0000;
    end
    next_c.rd_pend = rd_req;
  end
  // core registers
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      c       <= '0;
      c.cfg   <= scp_pkg::CONFIG_RESET;
      c.rbk   <= scp_pkg::READBACK_RESET;
      c.scl_s <= 2'h3;
      c.sda_s <= 2'h3;
      c.scl_q <= 1'b1;
      c.sda_q <= 1'b1;
      c.oe_n  <= 1'b1;
      c.ist   <= scp_pkg::I_IDLE;
    end else begin
      c <= next_c;
    end
  end

  // ==========================================================================
  // buffered and active copies
  scp_mem u_buf (.clk_i(CLK_I), .we_i(buf_we), .waddr_i(wa), .wdata_i(wd), .raddr_i(ra),
                 .rdata_o(buf_rdata));
  scp_mem u_act (.clk_i(CLK_I), .we_i(c.cp_wr), .waddr_i(c.cp_waddr), .wdata_i(buf_rdata),
                 .raddr_i(ra), .rdata_o(act_rdata));
  // clock line is input only; data line is open drain
  assign SDA_O         = 1'b0;
  assign SDA_OE_N_O    = c.oe_n;
  assign UPDATE_BUSY_O = c.cp_busy;
  assign LSB_FIRST_O   = c.cfg[scp_pkg::LSB_FIRST_BIT];

  // ==========================================================================
  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  sequence s_rx_nack;
    (c.ist == scp_pkg::I_RX_ACK) && c.phase && scl_fall && !c.ack;
  endsequence

  chk_instr_ptr_load: assert property (ev_pulse && ev.kind == scp_pkg::EV_INSTR
    |=> c.ptr == $past(instr_w[12:0])) else $error("instruction address not loaded");
  chk_cfg_live: assert property (buf_we && wa == scp_pkg::CONFIG_ADDR
    |=> LSB_FIRST_O == $past(wd[6])) else $error("bit order not live");
  chk_desc_step: assert property (ev_pulse && ev.kind == scp_pkg::EV_END && !c.spi_rd
    && !c.cfg[5] |=> c.ptr == $past(c.ptr) - 13'h0001) else $error("no decrement");
  chk_asc_step: assert property (ev_pulse && ev.kind == scp_pkg::EV_END && !c.spi_rd
    && c.cfg[5] |=> c.ptr == $past(c.ptr) + 13'h0001) else $error("no increment");
  chk_nack_idle: assert property (s_rx_nack |=> c.ist == scp_pkg::I_IDLE
    ##1 SDA_OE_N_O) else $error("no idle after own refusal");
  chk_rd_nack_end: assert property ((c.ist == scp_pkg::I_TX_ACK) && scl_rise
    && !c.phase && c.sda_s[1] |=> c.ist == scp_pkg::I_IDLE) else $error("read not ended");
  chk_start_abort: assert property (start |=> c.ist == scp_pkg::I_RX
    && c.bitc == 4'h0 && SDA_OE_N_O) else $error("start did not restart");
  chk_sda_low_scl: assert property ($changed(SDA_OE_N_O) && !$past(start)
    && !$past(stop) |-> !c.scl_s[1]) else $error("data changed with clock high");
  chk_ack_drive: assert property ((c.ist == scp_pkg::I_RX_ACK) && !c.phase
    && scl_fall && c.ack |=> !SDA_OE_N_O) else $error("acknowledge not driven");
  chk_update_copy: assert property (buf_we && wa == scp_pkg::UPDATE_ADDR
    && wd == scp_pkg::UPDATE_CMD |=> UPDATE_BUSY_O ##1 u_act.we_i) else $error("no copy");

endmodule : scp_serial_port
`default_nettype wire

// ==== tb/scp_host_model.sv ====
// host model: four-wire master and two-wire bus master with the bus pull-up
`timescale 1ns/1ps
`default_nettype none
module scp_host_model (
  // four-wire side
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdio_o,
  input  wire logic sdo_i,
  // two-wire side
  output logic      scl_o,
  output logic      sda_o,
  input  wire logic dev_sda_i,
  input  wire logic dev_sda_oe_n_i
);
  logic       pull_low;
  int         q;
  logic [7:0] wbuf [4];
  logic [7:0] rbuf [4];

  // ==========================================================================
  // open-drain wire: low if either party pulls, pull-up otherwise
  assign sda_o = !(pull_low || (!dev_sda_oe_n_i && !dev_sda_i));

  // idle levels; serial clock stands still outside frames
  initial begin
    sclk_o   = 1'b0;
    cs_n_o   = 1'b1;
    sdio_o   = 1'b0;
    scl_o    = 1'b1;
    pull_low = 1'b0;
    q        = 625;
  end

  // ==========================================================================
  // one sclk period: data set while low, answer taken just before the rise
  task automatic spi_bit(input logic b, output logic s);
    sdio_o = b;
    #15 s = sdo_i;
    sclk_o = 1'b1;
    #15 sclk_o = 1'b0;
  endtask : spi_bit

  // instruction word first, then n bytes over written places only
  task automatic spi(input logic lsb, input logic [15:0] w, input int n);
    logic       s;
    logic [7:0] b;
    cs_n_o = 1'b0;
    #20;
    for (int k = 0; k < 16; k++) begin
      spi_bit(w[lsb ? k : 15 - k], s);
    end
    #300;                            // pause lets the core fetch read data
    for (int j = 0; j < n; j++) begin
      for (int k = 0; k < 8; k++) begin
        spi_bit(wbuf[j][lsb ? k : 7 - k], s);
        b[lsb ? k : 7 - k] = s;
      end
      rbuf[j] = b;
    end
    #200 cs_n_o = 1'b1;
    sdio_o = !sdio_o;                // released line shows no stale value
    #60;                             // chip select stays high between frames
  endtask : spi

  // ==========================================================================
  // start or repeated start: sda falls while scl high
  task automatic i2c_start();
    pull_low = 1'b0;
    #q scl_o = 1'b1;
    #q pull_low = 1'b1;
    #q scl_o = 1'b0;
    #q;
  endtask : i2c_start

  // stop: sda rises while scl high
  task automatic i2c_stop();
    pull_low = 1'b1;
    #q scl_o = 1'b1;
    #q pull_low = 1'b0;
    #(2 * q);
  endtask : i2c_stop

  // host makes every clock and moves sda only while scl low
  task automatic i2c_bit(input logic b, output logic s);
    pull_low = !b;
    #q scl_o = 1'b1;
    #q s = sda_o;
    #q scl_o = 1'b0;
    #q;
  endtask : i2c_bit

  // eight bits msb first, then the ack slot; host nack ends a read
  task automatic i2c_byte(input logic [7:0] b, input logic ack_in, output logic [7:0] r,
                          output logic ack);
    for (int k = 7; k >= 0; k--) begin
      i2c_bit(b[k], r[k]);
    end
    i2c_bit(ack_in, ack);
  endtask : i2c_byte
endmodule : scp_host_model
`default_nettype wire

// ==== tb/serial_control_port_bench.sv ====
// self-checking bench of the serial register port
`timescale 1ns/1ps
`default_nettype none
module serial_control_port_bench;
  // ==========================================================================
  // wiring
  localparam logic [6:0] own = scp_pkg::SLAVE_ADDR_DEF;
  logic clk;
  logic rst_n;
  logic sclk, cs_n, sdio, sdo, scl, sda, dev_sda, dev_oe_n, busy, lsb_first;
  int   fails;
  int   n_compared;

  scp_serial_port #(.SLAVE_ADDR(own)) dut (
    .CLK_I(clk), .RESET_N_I(rst_n), .SCLK_I(sclk), .CS_N_I(cs_n), .SDIO_I(sdio), .SDO_O(sdo),
    .SCL_I(scl), .SDA_I(sda), .SDA_O(dev_sda), .SDA_OE_N_O(dev_oe_n),
    .UPDATE_BUSY_O(busy), .LSB_FIRST_O(lsb_first));

  scp_host_model host (
    .sclk_o(sclk), .cs_n_o(cs_n), .sdio_o(sdio), .sdo_i(sdo), .scl_o(scl), .sda_o(sda),
    .dev_sda_i(dev_sda), .dev_sda_oe_n_i(dev_oe_n));

  // system clock, 20 ns
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ==========================================================================
  // helpers
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic l, input logic [15:0] a, input logic [7:0] d);
    host.wbuf[0] = d;
    host.spi(l, a, 1);
  endtask : wr

  task automatic rd(input logic l, input logic [15:0] a, input logic [7:0] exp, input string w);
    host.spi(l, 16'h8000 | a, 1);
    check(w, host.rbuf[0], exp);
  endtask : rd

  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic [7:0] r;
    logic       a;
    host.i2c_byte(b, 1'b1, r, a);
    check("ack slot", 8'(a), 8'(exp_ack));
  endtask : send

  // device may move sda only while the clock is low
  always @(dev_oe_n) begin
    if (rst_n) check("scl at sda change", 8'(scl), 8'h00);
  end

  // ==========================================================================
  // scenarios
  task automatic t_spi_down();
    host.wbuf[0] = 8'hab;
    host.wbuf[1] = 8'hcd;
    host.spi(1'b0, 16'h0012, 2);
    host.spi(1'b0, 16'h8012, 2);
    check("rd 0x12", host.rbuf[0], 8'hab);
    check("rd 0x11", host.rbuf[1], 8'hcd);
    check("lsb flag", 8'(lsb_first), 8'h00);
    wr(1'b0, 16'h6010, 8'h3c);
    rd(1'b0, 16'h0010, 8'h3c, "rd 0x10");
  endtask : t_spi_down

  // copy walks the whole map; readback source follows the select bit
  task automatic t_update();
    int n;
    wr(1'b0, 16'h000f, 8'h01);
    for (n = 0; n < 20 && busy !== 1'b1; n++) @(negedge clk);
    n = 0;                           // look mid-cycle, where the busy flag has settled
    while (busy === 1'b1 && n < 10000) begin
      @(negedge clk);
      n++;
    end
    check("copy long enough", 8'(n >= 8180), 8'h01);
    check("copy done", 8'(busy), 8'h00);
    wr(1'b0, 16'h0012, 8'h77);
    wr(1'b0, 16'h0001, 8'h20);
    rd(1'b0, 16'h0012, 8'hab, "active 0x12");
    wr(1'b0, 16'h0001, 8'h00);
    rd(1'b0, 16'h0012, 8'h77, "buffered 0x12");
  endtask : t_update

  task automatic t_spi_up_lsb();
    wr(1'b0, 16'h0000, 8'h20);
    host.wbuf[0] = 8'h01;
    host.wbuf[1] = 8'h02;
    host.spi(1'b0, 16'h0020, 2);
    host.spi(1'b0, 16'h8020, 2);
    check("rd 0x20", host.rbuf[0], 8'h01);
    check("rd 0x21", host.rbuf[1], 8'h02);
    wr(1'b0, 16'h0000, 8'h60);
    check("lsb flag", 8'(lsb_first), 8'h01);
    wr(1'b1, 16'h0022, 8'h35);
    rd(1'b1, 16'h0022, 8'h35, "lsb rd 0x22");
    wr(1'b1, 16'h0000, 8'h00);
    rd(1'b0, 16'h0022, 8'h35, "msb rd 0x22");
  endtask : t_spi_up_lsb

  task automatic t_i2c_wr_rd();
    logic [7:0] r;
    logic       a;
    host.i2c_start();
    send({own, 1'b0}, 1'b0);
    send(8'h01, 1'b0);
    send(8'h30, 1'b0);
    send(8'ha5, 1'b0);
    send(8'h5a, 1'b0);
    host.i2c_stop();
    host.spi(1'b0, 16'h8131, 2);
    check("i2c wr 0x131", host.rbuf[0], 8'h5a);
    check("i2c wr 0x130", host.rbuf[1], 8'ha5);
    host.i2c_start();
    send({own, 1'b0}, 1'b0);
    send(8'h01, 1'b0);
    send(8'h30, 1'b0);
    host.i2c_start();
    send({own, 1'b1}, 1'b0);
    host.i2c_byte(8'hff, 1'b0, r, a);
    check("i2c rd 0x130", r, 8'ha5);
    host.i2c_byte(8'hff, 1'b1, r, a);
    check("i2c rd 0x131", r, 8'h5a);
    host.i2c_stop();
  endtask : t_i2c_wr_rd

  // standard-mode rate; foreign address is ignored to the next start
  task automatic t_i2c_slow();
    host.q = 2500;
    host.i2c_start();
    send({own ^ 7'h01, 1'b0}, 1'b1);
    send(8'h00, 1'b1);
    host.i2c_stop();
    host.i2c_start();
    send({own, 1'b0}, 1'b0);
    send(8'h00, 1'b0);
    send(8'h50, 1'b0);
    send(8'h66, 1'b0);
    host.i2c_stop();
    host.q = 625;
    rd(1'b0, 16'h0050, 8'h66, "slow wr 0x50");
  endtask : t_i2c_slow

  // repeated start cuts a byte in half; the rest must be dropped
  task automatic t_i2c_abort();
    logic s;
    host.i2c_start();
    send({own, 1'b0}, 1'b0);
    send(8'h00, 1'b0);
    send(8'h40, 1'b0);
    send(8'h11, 1'b0);
    for (int k = 0; k < 4; k++) host.i2c_bit(1'b1, s);
    host.i2c_start();
    send({own, 1'b0}, 1'b0);
    send(8'h00, 1'b0);
    send(8'h41, 1'b0);
    send(8'h22, 1'b0);
    host.i2c_stop();
    host.spi(1'b0, 16'h8041, 2);
    check("abort 0x41", host.rbuf[0], 8'h22);
    check("abort 0x40", host.rbuf[1], 8'h11);
  endtask : t_i2c_abort

  // ==========================================================================
  // verdict
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  // main sequence
  initial begin
    fails = 0;
    n_compared = 0;
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    #2 rst_n = 1'b1;
    repeat (5) @(posedge clk);
    #2;
    check("busy at reset", 8'(busy), 8'h00);
    check("sda oe at reset", 8'(dev_oe_n), 8'h01);
    t_spi_down();
    t_update();
    t_spi_up_lsb();
    t_i2c_wr_rd();
    t_i2c_slow();
    t_i2c_abort();
    complete_run();
  end

  // watchdog, above the expected run of about 1.2 ms, under 100k clocks
  initial begin
    #1900000;
    fails++;
    complete_run();
  end
endmodule : serial_control_port_bench
`default_nettype wire
